// ==== hdl/ress_pkg.sv ====
/*
 * constants for the receive signaling / elastic store block:
 * register offsets, field positions, reset values and framing counts.
 * assumes an 8-bit register port with 8-bit offsets.
 */
package ress_pkg;
    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_ES_CFG = 8'h7C;
    localparam logic [7:0] ADDR_ES_EVT = 8'h7D;
    localparam logic [7:0] ADDR_ES_CODE = 8'h7E;
    localparam logic [7:0] ADDR_MODE = 8'hD0;
    localparam logic [7:0] ADDR_SIG_CFG = 8'hD2;
    localparam logic [7:0] ADDR_ACC_STAT = 8'hD3;
    localparam logic [7:0] ADDR_ACC_CTL = 8'hD4;
    localparam logic [7:0] ADDR_ACC_DATA = 8'hD5;
    localparam logic [7:0] ADDR_CHG_BASE = 8'hD6;
    localparam int CHG_REGS = 4;
    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int ES_DIR_BIT = 0;
    localparam int ES_SLIPIE_BIT = 1;
    localparam int ES_SUBEN_BIT = 2;
    localparam int EVT_SLIP_BIT = 0;
    localparam int MODE_E1_BIT = 0;
    localparam int MODE_FMT_LSB = 1;
    localparam int MODE_MASTER_BIT = 3;
    localparam int MODE_LOOP_BIT = 4;
    localparam int MODE_MUX_BIT = 5;
    localparam int SIG_DEB_BIT = 0;
    localparam int SIG_FREEZE_BIT = 1;
    localparam int SIG_SIXTEEN_BIT = 2;
    localparam int SIG_CHGIE_BIT = 3;
    localparam int ACC_DIR_BIT = 7;
    localparam int STAT_BUSY_BIT = 0;
    localparam int ENTRY_CAPTURE_BIT = 4;
    // ------------------------------------------------------------------
    // formats, reset values, counts
    // ------------------------------------------------------------------
    localparam logic [1:0] FMT_SF = 2'h0;
    localparam logic [1:0] FMT_ESF = 2'h1;
    localparam logic [1:0] FMT_SLC = 2'h2;
    localparam logic [1:0] FMT_DM = 2'h3;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [3:0] RST_NIBBLE = 4'h0;
    localparam int SLIP_MARGIN = 2;
    localparam int FRAMES_PER_STEP = 6;
    localparam int STEPS_T1 = 4;
    localparam int E1_SIG_TS = 16;
    localparam int E1_SIG_FRAMES = 16;
    localparam logic [3:0] MASK_AB = 4'hC;
    localparam logic [3:0] MASK_ALL = 4'hF;
    localparam logic [2:0] LAST_BIT = 3'h7;
endpackage

// ==== hdl/ress_rx_sig_store.sv ====
/*
 * receive signaling buffer and two-frame elastic store for one link.
 * assumes the framer delivers received bytes on core_clk_in with slot
 * and frame-in-multiframe numbers, and that the backplane clock and
 * frame pulse pins are asynchronous and far slower than core_clk_in.
 */
// Implementation choice: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module ress_rx_sig_store #(
    parameter int SLOTS = 32,
    parameter int FRAME_W = 7
) (
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    input wire logic line_valid_in,
    input wire logic line_first_in,
    input wire logic [$clog2(SLOTS)-1:0] line_slot_in,
    input wire logic [FRAME_W-1:0] line_frame_in,
    input wire logic [7:0] line_byte_in,
    input wire logic frame_sync_lost_in,
    input wire logic mf_sync_lost_in,
    input wire logic system_receive_clock_pin_in,
    input wire logic system_frame_pulse_pin_in,
    output logic receive_data_out_pin_out,
    output logic signaling_out_pin_out,
    output logic irq_out
);
    localparam int LW = $clog2(SLOTS);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [2*SLOTS-1:0][7:0] store;
        logic wr_frame;
        logic [LW-1:0] wr_slot;
        logic rd_frame;
        logic [LW-1:0] rd_slot;
        logic [2:0] bit_cnt;
        logic [7:0] data_sh;
        logic [7:0] sig_sh;
        logic [2:0] clk_sync;
        logic [1:0] fp_sync;
        logic [SLOTS-1:0][4:0] entry;
        logic [SLOTS-1:0][3:0] stage;
        logic [SLOTS-1:0][3:0] last_code;
        logic [SLOTS-1:0] chg;
        logic slip_hold;
        logic slip_dir;
        logic slip_flag;
        logic slip_ie;
        logic sub_en;
        logic [7:0] fill_code;
        logic [7:0] mode;
        logic [7:0] sig_cfg;
        logic [7:0] acc_ctl;
        logic [7:0] acc_data;
        logic busy;
        logic [7:0] rd_data;
        logic [7:0] bypass_byte;
    } ress_state_t;

    ress_state_t q;
    ress_state_t d;

    logic e1;
    logic [1:0] fmt;
    logic store_on;
    logic hold;
    logic clk_rise;
    logic load;
    logic slip_now;
    logic slip_ahead;
    logic [LW:0] gap;
    logic [LW-1:0] idx;

    assign e1 = q.mode[ress_pkg::MODE_E1_BIT];
    assign fmt = q.mode[ress_pkg::MODE_FMT_LSB +: 2];
    // muxed mode counts as slave: the store is in the path either way
    assign store_on = !q.mode[ress_pkg::MODE_MASTER_BIT]
        || q.mode[ress_pkg::MODE_MUX_BIT] || q.mode[ress_pkg::MODE_LOOP_BIT];
    assign hold = frame_sync_lost_in || q.slip_hold || q.sig_cfg[ress_pkg::SIG_FREEZE_BIT]
        || (e1 && mf_sync_lost_in);
    // first sync stage is read only by the second
    assign clk_rise = q.clk_sync[1] && !q.clk_sync[2];
    assign load = clk_rise && (q.fp_sync[1] || q.bit_cnt == ress_pkg::LAST_BIT);
    assign gap = {q.wr_frame, q.wr_slot} - {!q.rd_frame, LW'(0)};
    assign slip_now = store_on && clk_rise && q.fp_sync[1]
        && (gap <= (LW+1)'(ress_pkg::SLIP_MARGIN)
        || gap >= (LW+1)'(2*SLOTS-ress_pkg::SLIP_MARGIN));
    assign slip_ahead = gap >= (LW+1)'(2*SLOTS-ress_pkg::SLIP_MARGIN);
    assign idx = q.acc_ctl[LW-1:0];

    assign reg_rdata_out = q.rd_data;
    assign receive_data_out_pin_out = q.data_sh[7];
    assign signaling_out_pin_out = q.sig_sh[7];
    assign irq_out = (q.slip_flag && q.slip_ie)
        || (q.sig_cfg[ress_pkg::SIG_CHGIE_BIT] && |q.chg);

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        logic [3:0] code;
        logic [3:0] mask;
        logic [3:0] sb;
        logic [3:0] nv;
        logic upd;
        logic bitv;
        logic nrf;
        logic [LW-1:0] nslot;
        int kk;
        int fr;
        int ts;
        code = ress_pkg::RST_NIBBLE;
        mask = ress_pkg::MASK_ALL;
        sb = ress_pkg::RST_NIBBLE;
        nv = ress_pkg::RST_NIBBLE;
        upd = 1'b0;
        bitv = line_byte_in[0];
        nrf = !q.rd_frame;
        nslot = '0;
        fr = int'(line_frame_in);
        ts = int'(line_slot_in);
        kk = ((fr + 1) / ress_pkg::FRAMES_PER_STEP - 1) % ress_pkg::STEPS_T1;
        d = q;
        d.clk_sync = {q.clk_sync[1:0], system_receive_clock_pin_in};
        d.fp_sync = {q.fp_sync[0], system_frame_pulse_pin_in};

        // register writes; clears come before hardware sets below
        if (reg_wr_in) begin
            unique case (reg_addr_in)
                ress_pkg::ADDR_ES_CFG: begin
                    d.slip_ie = reg_wdata_in[ress_pkg::ES_SLIPIE_BIT];
                    d.sub_en = reg_wdata_in[ress_pkg::ES_SUBEN_BIT];
                end
                ress_pkg::ADDR_ES_EVT: begin
                    if (reg_wdata_in[ress_pkg::EVT_SLIP_BIT]) begin
                        d.slip_flag = 1'b0;
                    end
                end
                ress_pkg::ADDR_ES_CODE: d.fill_code = reg_wdata_in;
                ress_pkg::ADDR_MODE: d.mode = reg_wdata_in;
                ress_pkg::ADDR_SIG_CFG: d.sig_cfg = reg_wdata_in;
                ress_pkg::ADDR_ACC_CTL: begin
                    d.acc_ctl = reg_wdata_in;
                    d.busy = 1'b1;
                end
                ress_pkg::ADDR_ACC_DATA: d.acc_data = reg_wdata_in;
                default: begin
                    for (int r = 0; r < ress_pkg::CHG_REGS; r++) begin
                        if (reg_addr_in == ress_pkg::ADDR_CHG_BASE + 8'(r)) begin
                            d.chg[r*8 +: 8] = q.chg[r*8 +: 8] & ~reg_wdata_in;
                        end
                    end
                end
            endcase
        end

        // indirect access completes one cycle after the control write
        if (q.busy) begin
            d.busy = 1'b0;
            if (int'(q.acc_ctl[6:0]) < SLOTS) begin
                if (q.acc_ctl[ress_pkg::ACC_DIR_BIT]) begin
                    d.acc_data = {3'h0, q.entry[idx]};
                end else begin
                    d.entry[idx] = q.acc_data[4:0];
                end
            end else if (q.acc_ctl[ress_pkg::ACC_DIR_BIT]) begin
                d.acc_data = ress_pkg::RST_BYTE;
            end
        end

        // line side: write pointer and signaling extraction
        if (line_valid_in) begin
            d.wr_frame = line_first_in ? !q.wr_frame : q.wr_frame;
            d.wr_slot = line_slot_in;
            d.store[{d.wr_frame, line_slot_in}] = line_byte_in;
            d.bypass_byte = line_byte_in;
            if (line_first_in && line_frame_in == '0) begin
                d.slip_hold = 1'b0;
            end
        end
        for (int i = 0; i < SLOTS; i++) begin
            upd = 1'b0;
            mask = ress_pkg::MASK_ALL;
            code = ress_pkg::RST_NIBBLE;
            sb = q.stage[i];
            if (line_valid_in && e1 && ts == ress_pkg::E1_SIG_TS
                    && fr > 0 && fr < ress_pkg::E1_SIG_FRAMES) begin
                if (i == fr) begin
                    code = line_byte_in[7:4];
                    upd = 1'b1;
                end else if (i == fr + ress_pkg::E1_SIG_TS) begin
                    code = line_byte_in[3:0];
                    upd = 1'b1;
                end
            end else if (line_valid_in && !e1 && fmt != ress_pkg::FMT_DM
                    && (fr + 1) % ress_pkg::FRAMES_PER_STEP == 0 && i == ts + 1) begin
                // bit 8 is the last bit on the wire, the byte's lsb
                if (fmt == ress_pkg::FMT_SF) begin
                    if (kk % 2 == 0) begin
                        sb[3] = bitv;
                    end else begin
                        code = {sb[3], bitv, sb[3], bitv};
                        upd = 1'b1;
                    end
                end else if (q.sig_cfg[ress_pkg::SIG_SIXTEEN_BIT]) begin
                    sb[3-kk] = bitv;
                    code = sb;
                    upd = kk == ress_pkg::STEPS_T1 - 1;
                end else begin
                    sb[3 - kk % 2] = bitv;
                    code = sb;
                    mask = ress_pkg::MASK_AB;
                    upd = kk % 2 == 1;
                end
                d.stage[i] = sb;
            end
            if (upd) begin
                d.last_code[i] = code;
                if (q.entry[i][ress_pkg::ENTRY_CAPTURE_BIT] && !hold
                        && (!q.sig_cfg[ress_pkg::SIG_DEB_BIT] || code == q.last_code[i])) begin
                    nv = (code & mask) | (q.entry[i][3:0] & ~mask);
                    if (nv != q.entry[i][3:0]) begin
                        d.entry[i][3:0] = nv;
                        d.chg[i] = 1'b1;
                    end
                end
            end
        end

        // system side: retimed read and serial output
        if (clk_rise) begin
            d.bit_cnt = q.fp_sync[1] ? '0 : q.bit_cnt + 3'h1;
            d.data_sh = {q.data_sh[6:0], 1'b0};
            d.sig_sh = {q.sig_sh[6:0], 1'b0};
        end
        if (load) begin
            if (q.fp_sync[1]) begin
                nslot = '0;
                // with two frames, a delete and a repeat both reread this frame
                if (slip_now) begin
                    nrf = q.rd_frame;
                    d.slip_dir = slip_ahead;
                    d.slip_flag = 1'b1;
                    d.slip_hold = 1'b1;
                end
            end else begin
                nrf = q.rd_frame;
                nslot = (int'(q.rd_slot) == SLOTS - 1) ? q.rd_slot : q.rd_slot + LW'(1);
            end
            d.rd_frame = nrf;
            d.rd_slot = nslot;
            if (!store_on) begin
                d.data_sh = q.bypass_byte;
            end else if (q.sub_en && frame_sync_lost_in) begin
                d.data_sh = q.fill_code;
            end else begin
                d.data_sh = q.store[{nrf, nslot}];
            end
            // T1 channel n sits in slot n-1; E1 slots 0 and 16 carry don't-care
            d.sig_sh = {4'h0, q.entry[e1 ? nslot : nslot + LW'(1)][3:0]};
        end

        // register reads answer one cycle later
        d.rd_data = ress_pkg::RST_BYTE;
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                ress_pkg::ADDR_ES_CFG: d.rd_data = {5'h00, q.sub_en, q.slip_ie, q.slip_dir};
                ress_pkg::ADDR_ES_EVT: d.rd_data = {7'h00, q.slip_flag};
                ress_pkg::ADDR_ES_CODE: d.rd_data = q.fill_code;
                ress_pkg::ADDR_MODE: d.rd_data = q.mode;
                ress_pkg::ADDR_SIG_CFG: d.rd_data = q.sig_cfg;
                ress_pkg::ADDR_ACC_STAT: d.rd_data = {7'h00, q.busy};
                ress_pkg::ADDR_ACC_CTL: d.rd_data = q.acc_ctl;
                ress_pkg::ADDR_ACC_DATA: d.rd_data = q.acc_data;
                default: begin
                    for (int r = 0; r < ress_pkg::CHG_REGS; r++) begin
                        if (reg_addr_in == ress_pkg::ADDR_CHG_BASE + 8'(r)) begin
                            d.rd_data = q.chg[r*8 +: 8];
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    sequence s_slip;
        slip_now;
    endsequence
    sequence s_lost;
        frame_sync_lost_in && !q.busy;
    endsequence

    a_slip_sets_flag: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        s_slip |=> q.slip_flag && q.slip_hold)
        else $error("slip did not set flag");
    a_slip_dir_ahead: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        s_slip and slip_ahead |=> q.slip_dir && $stable(q.rd_frame))
        else $error("delete slip direction wrong");
    a_slip_dir_lag: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        s_slip and !slip_ahead |=> !q.slip_dir && $stable(q.rd_frame))
        else $error("repeat slip direction wrong");
    a_irq_from_slip: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        q.slip_flag && q.slip_ie |-> irq_out)
        else $error("slip interrupt missing");
    a_irq_from_change: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (|q.chg) && q.sig_cfg[ress_pkg::SIG_CHGIE_BIT] |-> irq_out)
        else $error("change interrupt missing");
    a_busy_one_cycle: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        reg_wr_in && reg_addr_in == ress_pkg::ADDR_ACC_CTL |=> q.busy ##1 !q.busy)
        else $error("indirect busy wrong length");
    a_freeze_entries: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        s_lost |=> $stable(q.entry))
        else $error("entries changed while frozen");
    a_fill_code_out: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        load && store_on && q.sub_en && frame_sync_lost_in |=> q.data_sh == $past(q.fill_code))
        else $error("substitute code not loaded");
    a_bypass_path: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        load && !store_on |=> q.data_sh == $past(q.bypass_byte))
        else $error("bypass byte not loaded");
    a_dm_no_extract: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        line_valid_in && !e1 && fmt == ress_pkg::FMT_DM && !q.busy |=> $stable(q.entry))
        else $error("entries changed in multiplexer format");
    a_slip_hold_entries: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        q.slip_hold && !q.busy |=> $stable(q.entry))
        else $error("entries changed after slip");
    a_read_data_idle: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        !reg_rd_in |=> q.rd_data == ress_pkg::RST_BYTE)
        else $error("read data stood too long");
    a_slip_flag_clear: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        reg_wr_in && reg_addr_in == ress_pkg::ADDR_ES_EVT
        && reg_wdata_in[ress_pkg::EVT_SLIP_BIT] && !slip_now |=> !q.slip_flag)
        else $error("slip flag not cleared");
endmodule
`default_nettype wire

// ==== dv/ress_backplane_model.sv ====
/*
 * backplane model: makes the receive clock and frame pulse pins and
 * collects the serial data and signaling bytes of each slot.
 * assumes the block shifts msb first, launched after a pin clock rise.
 */
`timescale 1ns/100ps
`default_nettype none
module ress_backplane_model (
    input wire logic data_in,
    input wire logic sig_in,
    output logic clk_out,
    output logic fp_out
);
    logic [7:0] dsh;
    logic [7:0] ssh;
    logic [7:0] data_q[$];
    logic [7:0] sig_q[$];
    // ----------------------------------------
    // pin clock, frame pulse, capture
    // ----------------------------------------
    // clock stands low between frames, so no read slot moves then
    initial begin
        clk_out = 1'b0;
        fp_out = 1'b0;
    end
    task automatic run_slots(input int n);
        data_q.delete();
        sig_q.delete();
        #3 fp_out = 1'b1;
        for (int i = 0; i < n * 8; i++) begin
            #80 clk_out = 1'b1;
            #80 clk_out = 1'b0;
            fp_out = 1'b0;
            // sampled half a period after the clock rise, well clear of the change
            dsh = {dsh[6:0], data_in};
            ssh = {ssh[6:0], sig_in};
            if (i % 8 == 7) begin
                data_q.push_back(dsh);
                sig_q.push_back(ssh);
            end
        end
    endtask
endmodule
`default_nettype wire

// ==== dv/ress_rx_sig_store_test.sv ====
/*
 * testbench: registers, indirect entries, extraction, serial output,
 * substitution and slips, checked against a model of the entries.
 * assumes the backplane model drives the pin clock only inside frames.
 */
`timescale 1ns/100ps
`default_nettype none
module ress_rx_sig_store_test;
    logic clk;
    logic rst_n;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
    logic lv;
    logic lf;
    logic [4:0] lsl;
    logic [6:0] lfr;
    logic [7:0] lby;
    logic fsl;
    logic mfl;
    logic pclk;
    logic pfp;
    logic dout;
    logic sout;
    logic irq;
    int error_cnt;
    int comparisons;
    logic [31:0] seed;
    logic [7:0] ent[32];
    logic [7:0] v;
    logic [7:0] code;
    logic [3:0] b;
    logic [7:0] rlist[4] = '{8'h7C, 8'h7D, 8'h7E, 8'hD2};
    int chans[4] = '{5, 7, 3, 19};
    ress_rx_sig_store ress_rx_sig_store_i (
        .core_clk_in(clk), .arst_n_in(rst_n), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .line_valid_in(lv), .line_first_in(lf), .line_slot_in(lsl),
        .line_frame_in(lfr), .line_byte_in(lby), .frame_sync_lost_in(fsl),
        .mf_sync_lost_in(mfl), .system_receive_clock_pin_in(pclk),
        .system_frame_pulse_pin_in(pfp), .receive_data_out_pin_out(dout),
        .signaling_out_pin_out(sout), .irq_out(irq));
    ress_backplane_model ress_backplane_model_i (
        .data_in(dout), .sig_in(sout), .clk_out(pclk), .fp_out(pfp));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
        @(posedge clk);
    endtask
    task automatic ind(input logic [7:0] ctl, output logic [7:0] d);
        logic [7:0] st;
        wr_reg(8'hD4, ctl);
        st = 8'h01;
        for (int i = 0; i < 8 && st[0] !== 1'b0; i++) begin
            rd_reg(8'hD3, st);
        end
        rd_reg(8'hD5, d);
    endtask
    task automatic line(input int sl, input int fr, input logic [7:0] by, input logic f);
        lv <= 1'b1;
        lf <= f;
        lsl <= sl[4:0];
        lfr <= fr[6:0];
        lby <= by;
        @(posedge clk);
        lv <= 1'b0;
        lf <= 1'b0;
        @(posedge clk);
    endtask
    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #500_000;
        error_cnt++;
        finish_test();
    end
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        {rst_n, addr, wdata, wr, rd, lv, lf, lsl, lfr, lby, fsl, mfl} = '0;
        seed = 32'hC570;
        foreach (ent[i]) ent[i] = 8'h00;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        foreach (rlist[i]) begin
            rd_reg(rlist[i], v);
            chk("reset value", 8'h00, v);
        end
        code = 8'(rnd());
        wr_reg(8'h7E, code);
        rd_reg(8'h7E, v);
        chk("fill code", code, v);
        rd_reg(8'h40, v);
        chk("unmapped", 8'h00, v);
        $display("test registers done");
        foreach (chans[i]) begin
            wr_reg(8'hD5, 8'h10);
            ind({1'b0, chans[i][6:0]}, v);
            ent[chans[i]] = 8'h10;
            ind({1'b1, chans[i][6:0]}, v);
            chk("entry write", 8'h10, v);
        end
        ind(8'hC0, v);
        chk("entry out of range", 8'h00, v);
        $display("test indirect done");
        wr_reg(8'hD0, 8'h08);
        line(0, 0, 8'h00, 1'b1);
        for (int i = 0; i < 4; i++) wr_reg(8'hD6 + i[7:0], 8'hFF);
        wr_reg(8'hD2, 8'h08);
        b = 4'(rnd());
        b[3] = 1'b1;
        line(4, 5, {7'h0, b[3]}, 1'b0);
        line(4, 11, {7'h0, b[2]}, 1'b0);
        ent[5] = {4'h1, b[3], b[2], b[3], b[2]};
        ind(8'h85, v);
        chk("sf entry", ent[5], v);
        rd_reg(8'hD6, v);
        chk("change flags", 8'h20, v);
        chk("change irq", 8'h01, {7'h0, irq});
        wr_reg(8'hD6, 8'hFF);
        rd_reg(8'hD6, v);
        chk("flags cleared", 8'h00, v);
        chk("irq cleared", 8'h00, {7'h0, irq});
        for (int k = 0; k < 3; k++) begin
            wr_reg(8'hD2, k == 0 ? 8'h02 : 8'h00);
            fsl <= (k == 1);
            wr_reg(8'hD0, k == 2 ? 8'h0E : 8'h08);
            line(4, 5, {7'h0, ~b[3]}, 1'b0);
            line(4, 11, {7'h0, ~b[2]}, 1'b0);
            ind(8'h85, v);
            chk("held entry", ent[5], v);
        end
        fsl <= 1'b0;
        $display("test t1 sf done");
        wr_reg(8'hD0, 8'h0A);
        for (int s = 0; s < 2; s++) begin
            wr_reg(8'hD2, s == 1 ? 8'h04 : 8'h00);
            b = 4'(rnd());
            for (int f = 0; f < 4; f++) line(6, 5 + 6 * f, {7'h0, b[3 - f]}, 1'b0);
            ent[7] = s == 1 ? {4'h1, b} : {4'h1, b[1:0], ent[7][1:0]};
            ind(8'h87, v);
            chk("esf entry", ent[7], v);
        end
        $display("test esf done");
        wr_reg(8'hD0, 8'h09);
        wr_reg(8'hD2, 8'h01);
        code = 8'(rnd());
        line(16, 3, code, 1'b0);
        ind(8'h83, v);
        chk("debounce first", 8'h10, v);
        line(16, 3, code, 1'b0);
        ent[3] = {4'h1, code[7:4]};
        ent[19] = {4'h1, code[3:0]};
        ind(8'h83, v);
        chk("e1 entry 3", ent[3], v);
        ind(8'h93, v);
        chk("e1 entry 19", ent[19], v);
        mfl <= 1'b1;
        line(16, 3, ~code, 1'b0);
        line(16, 3, ~code, 1'b0);
        ind(8'h83, v);
        chk("e1 mf hold", ent[3], v);
        mfl <= 1'b0;
        ress_backplane_model_i.run_slots(33);
        @(posedge clk);
        chk("sig slot 3", {4'h0, ent[3][3:0]}, ress_backplane_model_i.sig_q[3]);
        chk("sig slot 19", {4'h0, ent[19][3:0]}, ress_backplane_model_i.sig_q[19]);
        chk("bypass data", ~code, ress_backplane_model_i.data_q[0]);
        $display("test e1 done");
        wr_reg(8'hD0, 8'h18);
        fsl <= 1'b1;
        code = 8'(rnd());
        wr_reg(8'h7E, code);
        wr_reg(8'h7C, 8'h04);
        ress_backplane_model_i.run_slots(8);
        @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            chk("substitute", code, ress_backplane_model_i.data_q[i]);
        end
        $display("test substitute done");
        fsl <= 1'b0;
        wr_reg(8'hD0, 8'h29);
        wr_reg(8'h7C, 8'h02);
        wr_reg(8'h7D, 8'h01);
        for (int s = 0; s < 32; s++) line(s, 0, 8'(rnd()), s == 0);
        ress_backplane_model_i.run_slots(80);
        @(posedge clk);
        rd_reg(8'h7D, v);
        chk("slip flag", 8'h01, v);
        rd_reg(8'h7C, v);
        chk("slip direction", 8'h03, v);
        chk("slip irq", 8'h01, {7'h0, irq});
        wr_reg(8'h7D, 8'h01);
        rd_reg(8'h7D, v);
        chk("slip cleared", 8'h00, v);
        chk("slip irq off", 8'h00, {7'h0, irq});
        line(0, 0, 8'(rnd()), 1'b1);
        ress_backplane_model_i.run_slots(1);
        @(posedge clk);
        rd_reg(8'h7D, v);
        chk("repeat slip flag", 8'h01, v);
        rd_reg(8'h7C, v);
        chk("repeat slip direction", 8'h02, v);
        $display("test slip done");
        finish_test();
    end
endmodule
`default_nettype wire
